// [core/abscc_map.vh]
// Purpose: constants of the converter buffer and scan control block
// Assumes: 32-bit Avalon-MM slave, word addressing by byte offset
// Notes: bit positions and reset values of the control register
`ifndef ABSCC_MAP_VH
`define ABSCC_MAP_VH

`define ABSCC_OFS_CTRL2      4'h0
`define ABSCC_OFS_STAT       4'h4
`define ABSCC_OFS_IRQ_EN     4'h8
`define ABSCC_OFS_IRQ_CLR    4'hc

`define ABSCC_BIT_REF_HI     15
`define ABSCC_BIT_REF_LO     13
`define ABSCC_BIT_OFFSET_CALIBRATION_ENABLE     12
`define ABSCC_BIT_CHIDX      11
`define ABSCC_BIT_SCAN       10
`define ABSCC_BIT_FILLST     7
`define ABSCC_BIT_SPI_HI     5
`define ABSCC_BIT_SPI_LO     2
`define ABSCC_BIT_SPLIT      1

`define ABSCC_CTRL2_WMASK    32'h0000fc3e
`define ABSCC_CTRL2_RESET    32'h00000000

`define ABSCC_BUF_WORDS      22
`define ABSCC_HALF_WORDS     11
`define ABSCC_LAST_WORD      5'h15
`define ABSCC_HALF_LAST      5'h0a
`define ABSCC_HALF_FIRST     5'h0b

`define ABSCC_REF_ANALOG_SUPPLY_REFERENCE_ANALOG_GROUND_REFERENCE  3'h0
`define ABSCC_REF_ANALOG_SUPPLY_REFERENCE_EXTN  3'h1
`define ABSCC_REF_EXTP_ANALOG_GROUND_REFERENCE  3'h2
`define ABSCC_REF_EXTP_EXTN  3'h3

`define ABSCC_READ_LAT       1

`endif

// [core/abscc_scan_step.v]
// Purpose: picks the next input to scan from a 32-bit scan mask
// Assumes: i_mask one bit per input, i_cur the input just converted
// Notes: wraps round to the lowest set bit; zero mask keeps i_cur
`timescale 1ns/1ps
module abscc_scan_step (
  input  wire [31:0] i_mask,
  input  wire [4:0]  i_cur,
  output reg  [4:0]  o_next
);
  integer k;
  reg     found;
  reg [5:0] idx;
  always @*
  begin
    o_next = i_cur;
    found  = 1'b0;
    idx    = 6'h00;
    for (k = 1; k <= 32; k = k + 1)
    begin
      idx = {1'b0, i_cur} + k[5:0];
      if (!found && i_mask[idx[4:0]])
      begin
        o_next = idx[4:0];
        found  = 1'b1;
      end
    end
  end
endmodule

// [core/abscc_top.v]
// Purpose: converter control register two: reference, calibration, scan, buffer
// Assumes: converter core reports each result with i_conv_done and
//          each completed sample/convert sequence with i_seq_done
// Notes: registers over Avalon-MM, one wait cycle on every access
// Overview of operation
// - reference field picks supply/ground or external pins; 1xx is unused.
// - calibration bit ties sample-and-hold inputs to negative reference.
// - channel-indexed bit stores result at its channel slot (channels above 21 at slot 21), else FIFO order.
// - split mode uses two 11-word halves, otherwise one 22-word buffer.
// - fill status reads 1 while filling upper half, 0 while lower half.
// - four-bit field in bits 5..2 sets sequences per interrupt; 0 each.
// - unimplemented control bits ignore writes and read as zero.
//
// Decided for this implementation: the address map and the Avalon-MM slave port.
`timescale 1ns/1ps
`include "abscc_map.vh"
module abscc_top (
  input  wire        i_core_clk,
  input  wire        i_nrst,
  input  wire [3:0]  i_avs_address,
  input  wire        i_avs_read,
  input  wire        i_avs_write,
  input  wire [31:0] i_avs_writedata,
  input  wire [3:0]  i_avs_byteenable,
  output reg  [31:0] o_avs_readdata,
  output wire        o_avs_waitrequest,
  input  wire [4:0]  i_chan_fixed,
  input  wire [31:0] i_scan_mask,
  input  wire        i_conv_done,
  input  wire [9:0]  i_conv_result,
  input  wire        i_seq_done,
  output reg  [1:0]  o_ref_pos_sel,
  output reg  [1:0]  o_ref_neg_sel,
  output wire        o_sha_to_neg_ref,
  output wire [4:0]  o_sha_pos_chan,
  output reg         o_buf_we,
  output reg  [4:0]  o_buf_addr,
  output reg  [9:0]  o_buf_wdata,
  output wire        o_irq
);
  reg  [31:0] ctrl2_r;
  reg  [31:0] ctrl2_nxt;
  reg         ack_r;
  reg  [3:0]  seq_cnt_r;
  reg  [4:0]  wr_ptr_r;
  reg  [4:0]  scan_ch_r;
  reg  [1:0]  stat_r;
  reg  [1:0]  irq_en_r;
  reg         overrun_r;
  wire [4:0]  scan_nxt;
  wire [3:0]  spi_field;
  wire        split_mode;
  wire        fill_hi;
  wire        chan_idx;
  wire        scan_en;
  wire        seq_irq;
  wire        acc;
  wire        wr_hit;
  wire [4:0]  cur_chan;
  wire [4:0]  half_base;
  wire [4:0]  half_last;
  wire [31:0] be_mask;

  assign spi_field  = ctrl2_r[`ABSCC_BIT_SPI_HI:`ABSCC_BIT_SPI_LO];
  assign split_mode = ctrl2_r[`ABSCC_BIT_SPLIT];
  assign fill_hi    = ctrl2_r[`ABSCC_BIT_FILLST];
  assign chan_idx   = ctrl2_r[`ABSCC_BIT_CHIDX];
  assign scan_en    = ctrl2_r[`ABSCC_BIT_SCAN];

  // bus handshake: one wait cycle then acknowledge
  assign acc               = (i_avs_read | i_avs_write) & ~ack_r;
  assign o_avs_waitrequest = (i_avs_read | i_avs_write) & ~ack_r;
  assign wr_hit            = i_avs_write & ack_r;

  genvar g;
  generate
    for (g = 0; g < 4; g = g + 1)
    begin : g_be
      assign be_mask[g*8+7:g*8] = {8{i_avs_byteenable[g]}};
    end
  endgenerate

  always @(posedge i_core_clk or negedge i_nrst)
  begin
    if (!i_nrst)
      ack_r <= 1'b0;
    else
      ack_r <= acc;
  end

  // reference pair decode
  always @*
  begin
    case (ctrl2_r[`ABSCC_BIT_REF_HI:`ABSCC_BIT_REF_LO])
      `ABSCC_REF_ANALOG_SUPPLY_REFERENCE_ANALOG_GROUND_REFERENCE:
      begin
        o_ref_pos_sel = 2'h0;
        o_ref_neg_sel = 2'h0;
      end
      `ABSCC_REF_ANALOG_SUPPLY_REFERENCE_EXTN:
      begin
        o_ref_pos_sel = 2'h0;
        o_ref_neg_sel = 2'h1;
      end
      `ABSCC_REF_EXTP_ANALOG_GROUND_REFERENCE:
      begin
        o_ref_pos_sel = 2'h1;
        o_ref_neg_sel = 2'h0;
      end
      `ABSCC_REF_EXTP_EXTN:
      begin
        o_ref_pos_sel = 2'h1;
        o_ref_neg_sel = 2'h1;
      end
      default:
      begin
        o_ref_pos_sel = 2'h0;
        o_ref_neg_sel = 2'h0;
      end
    endcase
  end

  // input path
  assign o_sha_to_neg_ref = ctrl2_r[`ABSCC_BIT_OFFSET_CALIBRATION_ENABLE];
  assign cur_chan         = scan_en ? scan_ch_r : i_chan_fixed;
  assign o_sha_pos_chan   = cur_chan;

  abscc_scan_step u_scan (
    .i_mask (i_scan_mask),
    .i_cur  (scan_ch_r),
    .o_next (scan_nxt)
  );

  // sequence counter and interrupt point
  assign seq_irq = i_seq_done && (seq_cnt_r == spi_field);

  always @(posedge i_core_clk or negedge i_nrst)
  begin
    if (!i_nrst)
      seq_cnt_r <= 4'h0;
    else if (seq_irq)
      seq_cnt_r <= 4'h0;
    else if (i_seq_done)
      seq_cnt_r <= seq_cnt_r + 4'h1;
  end

  always @(posedge i_core_clk or negedge i_nrst)
  begin
    if (!i_nrst)
      scan_ch_r <= 5'h00;
    else if (!scan_en)
      scan_ch_r <= i_chan_fixed;
    else if (i_conv_done)
      scan_ch_r <= scan_nxt;
  end

  // fill window of the buffer
  assign half_base = (split_mode && fill_hi) ? `ABSCC_HALF_FIRST : 5'h00;
  assign half_last = split_mode ? (fill_hi ? `ABSCC_LAST_WORD : `ABSCC_HALF_LAST)
                                : `ABSCC_LAST_WORD;

  always @(posedge i_core_clk or negedge i_nrst)
  begin
    if (!i_nrst)
      wr_ptr_r <= 5'h00;
    else if (seq_irq)
    begin
      if (split_mode)
        wr_ptr_r <= fill_hi ? 5'h00 : `ABSCC_HALF_FIRST;
      else
        wr_ptr_r <= 5'h00;
    end
    else if (i_conv_done && !chan_idx)
    begin
      if (wr_ptr_r >= half_last)
        wr_ptr_r <= half_base;
      else
        wr_ptr_r <= wr_ptr_r + 5'h01;
    end
  end

  // result write strobe
  always @(posedge i_core_clk or negedge i_nrst)
  begin
    if (!i_nrst)
    begin
      o_buf_we    <= 1'b0;
      o_buf_addr  <= 5'h00;
      o_buf_wdata <= 10'h000;
    end
    else
    begin
      o_buf_we    <= i_conv_done;
      o_buf_wdata <= i_conv_result;
      if (chan_idx)
        o_buf_addr <= (cur_chan > `ABSCC_LAST_WORD) ? `ABSCC_LAST_WORD
                                                     : cur_chan;
      else
        o_buf_addr <= wr_ptr_r;
    end
  end

  // control register two
  always @*
  begin
    ctrl2_nxt = ctrl2_r;
    if (wr_hit && i_avs_address == `ABSCC_OFS_CTRL2)
      ctrl2_nxt = (ctrl2_r & ~(`ABSCC_CTRL2_WMASK & be_mask)) |
                  (i_avs_writedata & `ABSCC_CTRL2_WMASK & be_mask);
    if (!ctrl2_nxt[`ABSCC_BIT_SPLIT])
      ctrl2_nxt[`ABSCC_BIT_FILLST] = 1'b0;
    else if (seq_irq && split_mode)
      ctrl2_nxt[`ABSCC_BIT_FILLST] = ~fill_hi;
    else
      ctrl2_nxt[`ABSCC_BIT_FILLST] = fill_hi;
  end

  always @(posedge i_core_clk or negedge i_nrst)
  begin
    if (!i_nrst)
      ctrl2_r <= `ABSCC_CTRL2_RESET;
    else
      ctrl2_r <= ctrl2_nxt;
  end

  // interrupt status: bit0 sequence interrupt, bit1 overrun of the FIFO fill
  always @(posedge i_core_clk or negedge i_nrst)
  begin
    if (!i_nrst)
      overrun_r <= 1'b0;
    else
      overrun_r <= i_conv_done && !chan_idx && !seq_irq && (wr_ptr_r >= half_last);
  end

  always @(posedge i_core_clk or negedge i_nrst)
  begin
    if (!i_nrst)
    begin
      stat_r   <= 2'h0;
      irq_en_r <= 2'h0;
    end
    else
    begin
      if (wr_hit && i_avs_address == `ABSCC_OFS_IRQ_EN && i_avs_byteenable[0])
        irq_en_r <= i_avs_writedata[1:0];
      if (wr_hit && i_avs_address == `ABSCC_OFS_IRQ_CLR && i_avs_byteenable[0])
        stat_r <= (stat_r & ~i_avs_writedata[1:0]) | {overrun_r, seq_irq};
      else
        stat_r <= stat_r | {overrun_r, seq_irq};
    end
  end

  assign o_irq = |(stat_r & irq_en_r);

  // read data
  always @(posedge i_core_clk or negedge i_nrst)
  begin
    if (!i_nrst)
      o_avs_readdata <= 32'h00000000;
    else if (i_avs_read && !ack_r)
    begin
      case (i_avs_address)
        `ABSCC_OFS_CTRL2:   o_avs_readdata <= ctrl2_r & `ABSCC_CTRL2_WMASK | 
                                              {24'h000000, fill_hi, 7'h00};
        `ABSCC_OFS_STAT:    o_avs_readdata <= {30'h00000000, stat_r};
        `ABSCC_OFS_IRQ_EN:  o_avs_readdata <= {30'h00000000, irq_en_r};
        default:            o_avs_readdata <= 32'h00000000;
      endcase
    end
  end
endmodule

// [sim/abscc_top_properties.sv]
// Purpose: port checker of abscc_top
// Assumes: full byte enables on control writes
// Notes: sh_r shadows control two
`timescale 1ns/1ps
module abscc_chk (
  input wire        i_core_clk,
  input wire        i_nrst,
  input wire [3:0]  i_avs_address,
  input wire        i_avs_read,
  input wire        i_avs_write,
  input wire [31:0] i_avs_writedata,
  input wire [31:0] o_avs_readdata,
  input wire        o_avs_waitrequest,
  input wire [4:0]  i_chan_fixed,
  input wire        i_conv_done,
  input wire [9:0]  i_conv_result,
  input wire        i_seq_done,
  input wire [1:0]  o_ref_pos_sel,
  input wire [1:0]  o_ref_neg_sel,
  input wire        o_sha_to_neg_ref,
  input wire [4:0]  o_sha_pos_chan,
  input wire        o_buf_we,
  input wire [4:0]  o_buf_addr,
  input wire [9:0]  o_buf_wdata
);
  reg  [15:0] sh_r;
  wire        acc = !o_avs_waitrequest && i_avs_address == 4'h0;
  always @(posedge i_core_clk or negedge i_nrst)
    if (!i_nrst)
      sh_r <= 16'h0;
    else if (i_avs_write && acc)
      sh_r <= i_avs_writedata[15:0];
  default clocking @(posedge i_core_clk); endclocking
  default disable iff (!i_nrst);
  chk_ref_pos_pin: assert property (
    o_ref_pos_sel == {1'b0, sh_r[14] & !sh_r[15]}) else $error("positive reference wrong");
  chk_ref_neg_pin: assert property (
    o_ref_neg_sel == {1'b0, sh_r[13] & !sh_r[15]}) else $error("negative reference wrong");
  chk_offset_calibration_enable_route: assert property (
    o_sha_to_neg_ref == sh_r[12]) else $error("calibration route wrong");
  chk_fixed_chan: assert property (
    !sh_r[10] |-> o_sha_pos_chan == i_chan_fixed) else $error("fixed channel wrong");
  chk_slot_index: assert property (
    sh_r[11] && i_conv_done && !i_seq_done && o_sha_pos_chan < 5'h16
    |=> o_buf_addr == $past(o_sha_pos_chan)) else $error("slot not channel");
  chk_result_copy: assert property (
    i_conv_done |=> o_buf_we && o_buf_wdata == $past(i_conv_result)) else $error("bad store");
  chk_no_stray: assert property (
    !i_conv_done |=> !o_buf_we) else $error("stray store");
  chk_addr_range: assert property (
    o_buf_we |-> o_buf_addr < 5'h16) else $error("store beyond buffer");
  chk_rsvd_zero: assert property (
    i_avs_read && acc |-> (o_avs_readdata & 32'hffff0341) == 32'h0) else $error("reserved set");
  chk_fill_clear: assert property (
    i_avs_read && acc && !sh_r[1] |-> !o_avs_readdata[7]) else $error("fill status set");
  cover property (sh_r[1] && o_buf_we && o_buf_addr == 5'h0b);
  cover property (sh_r[11] && o_buf_we);
  cover property (sh_r[10] && o_buf_we);
endmodule

bind abscc_top abscc_chk chk_u (
  .i_core_clk        (i_core_clk),
  .i_nrst            (i_nrst),
  .i_avs_address     (i_avs_address),
  .i_avs_read        (i_avs_read),
  .i_avs_write       (i_avs_write),
  .i_avs_writedata   (i_avs_writedata),
  .o_avs_readdata    (o_avs_readdata),
  .o_avs_waitrequest (o_avs_waitrequest),
  .i_chan_fixed      (i_chan_fixed),
  .i_conv_done       (i_conv_done),
  .i_conv_result     (i_conv_result),
  .i_seq_done        (i_seq_done),
  .o_ref_pos_sel     (o_ref_pos_sel),
  .o_ref_neg_sel     (o_ref_neg_sel),
  .o_sha_to_neg_ref  (o_sha_to_neg_ref),
  .o_sha_pos_chan    (o_sha_pos_chan),
  .o_buf_we          (o_buf_we),
  .o_buf_addr        (o_buf_addr),
  .o_buf_wdata       (o_buf_wdata)
);

// [sim/tb_top.sv]
// Purpose: self-checking bench of abscc_top
// Assumes: scan mask holds inputs 3 and 7
// Notes: bus waits bounded to 20 cycles
`timescale 1ns/1ps
module tb_top;
  reg         clk = 1'b0;
  reg         nrst = 1'b0;
  reg  [3:0]  adr = 4'h0;
  reg         rd_en = 1'b0;
  reg         wr_en = 1'b0;
  reg  [31:0] wd = 32'h0;
  reg  [4:0]  chan = 5'h05;
  reg         cdone = 1'b0;
  reg  [9:0]  cres = 10'h0;
  reg         sdone = 1'b0;
  reg  [31:0] rv;
  wire [31:0] rdata;
  wire        wq, sneg, we, irq;
  wire [1:0]  rpos, rneg;
  wire [4:0]  pchan, badr;
  wire [9:0]  bdat;
  integer     err_count = 0;
  integer     cmp_count = 0;
  integer     i;
  always #5 clk = ~clk;
  abscc_top dut_u (.i_core_clk(clk), .i_nrst(nrst), .i_avs_address(adr),
    .i_avs_read(rd_en), .i_avs_write(wr_en), .i_avs_writedata(wd),
    .i_avs_byteenable(4'hf), .o_avs_readdata(rdata), .o_avs_waitrequest(wq),
    .i_chan_fixed(chan), .i_scan_mask(32'h88), .i_conv_done(cdone),
    .i_conv_result(cres), .i_seq_done(sdone), .o_ref_pos_sel(rpos),
    .o_ref_neg_sel(rneg), .o_sha_to_neg_ref(sneg), .o_sha_pos_chan(pchan),
    .o_buf_we(we), .o_buf_addr(badr), .o_buf_wdata(bdat), .o_irq(irq));
  task conclude;
    begin
      $display("errors %0d checks %0d", err_count, cmp_count);
      if (err_count == 0 && cmp_count > 0)
        $display("ALL CHECKS OK");
      else
        $display("CHECKS NOT OK");
      $finish;
    end
  endtask
  task chk(input [31:0] got, input [31:0] exp);
    begin
      cmp_count = cmp_count + 1;
      if (got !== exp)
      begin
        err_count = err_count + 1;
        $display("ERROR %0t got %h exp %h", $time, got, exp);
      end
    end
  endtask
  task bus(input w, input [3:0] a, input [31:0] d);
    integer n;
    reg     to;
    begin
      n = 0;
      @(posedge clk);
      adr   <= a;
      wd    <= d;
      wr_en <= w;
      rd_en <= !w;
      @(posedge clk);
      while (wq && n < 20)
      begin
        n = n + 1;
        @(posedge clk);
      end
      to = wq;
      rv = rdata;
      wr_en <= 1'b0;
      rd_en <= 1'b0;
      @(negedge clk);
      if (to)
      begin
        err_count = err_count + 1;
        $display("ERROR %0t bus wait timed out", $time);
        conclude;
      end
    end
  endtask
  task rc(input [3:0] a, input [31:0] e);
    begin
      bus(1'b0, a, 32'h0);
      chk(rv, e);
    end
  endtask
  task conv(input [9:0] r, input [4:0] a);
    begin
      @(posedge clk);
      cdone <= 1'b1;
      cres <= r;
      @(posedge clk);
      cdone <= 1'b0;
      @(negedge clk);
      chk({we, badr, bdat}, {1'b1, a, r});
    end
  endtask
  task seq(input integer k);
    begin
      repeat (k)
      begin
        @(posedge clk);
        sdone <= 1'b1;
        @(posedge clk);
        sdone <= 1'b0;
      end
      @(negedge clk);
    end
  endtask
  initial
  begin
    repeat (6) @(posedge clk);
    nrst <= 1'b1;
    rc(4'h0, 32'h0);
    rc(4'h2, 32'h0);
    bus(1'b1, 4'h0, 32'hffffffff);
    rc(4'h0, 32'h0000fc3e);
    for (i = 0; i < 8; i = i + 1)
    begin
      bus(1'b1, 4'h0, {i[2:0], i[0], 12'h0});
      chk({rpos, rneg, sneg, pchan}, {!i[2] && i[1], 1'b0, !i[2] && i[0], i[0], chan});
    end
    bus(1'b1, 4'h0, 32'h0800);
    conv(10'h155, chan);
    @(posedge clk);
    chan <= 5'h15;
    conv(10'h2aa, 5'h15);
    bus(1'b1, 4'h0, 32'h0c00);
    conv(10'h0f0, pchan);
    i = pchan;
    conv(10'h30f, pchan);
    chk({pchan & 5'h1b, pchan}, {5'h03, i[4:0] ^ 5'h04});
    bus(1'b1, 4'h0, 32'h0);
    bus(1'b1, 4'h8, 32'h1);
    seq(1);
    chk(irq, 1'b1);
    bus(1'b1, 4'hc, 32'h1);
    rc(4'h4, 32'h0);
    for (i = 0; i < 3; i = i + 1)
      conv(i[9:0], i[4:0]);
    bus(1'b1, 4'h0, 32'h8);
    seq(2);
    chk(irq, 1'b0);
    seq(1);
    chk(irq, 1'b1);
    bus(1'b1, 4'h8, 32'h0);
    chk(irq, 1'b0);
    rc(4'h4, 32'h1);
    bus(1'b1, 4'h0, 32'h2);
    rc(4'h0, 32'h2);
    seq(1);
    rc(4'h0, 32'h82);
    for (i = 0; i < 12; i = i + 1)
      conv(i[9:0], 5'h0b + i % 11);
    rc(4'h4, 32'h3);
    seq(1);
    rc(4'h0, 32'h2);
    conv(10'h3c3, 5'h00);
    conclude;
  end
endmodule
